// ### design/host_port_if.sv
// Purpose: Pin bundle between host and serial controller bus port
// Assumes: Both ends clocked by the same clk
// Notes:   Data bus level resolved here from the two enables
`timescale 1ns/100ps
`default_nettype none
interface host_port_if;
  logic       address_latch_strobe_n;
  logic       select_high_a;
  logic       select_high_b;
  logic       select_low_n;
  logic [2:0] register_index;
  logic       rd;
  logic       rd_n;
  logic       wr;
  logic       wr_n;
  logic [7:0] host_data_out;
  logic       host_data_oe;
  logic [7:0] dev_data_out;
  logic       dev_data_oe;
  logic [7:0] host_data_bus;
  logic       selected_indicator;
  logic       transceiver_disable;
  logic       irq_out;
  logic       irq_out_oe;

  // Undriven bus reads as all ones, like a pulled-up board
  assign host_data_bus = dev_data_oe ? dev_data_out : (host_data_oe ? host_data_out : 8'hff);

  modport device (
    input  address_latch_strobe_n, select_high_a, select_high_b, select_low_n, register_index,
    input  rd, rd_n, wr, wr_n, host_data_bus,
    output dev_data_out, dev_data_oe, selected_indicator, transceiver_disable, irq_out, irq_out_oe
  );
  modport host (
    output address_latch_strobe_n, select_high_a, select_high_b, select_low_n, register_index,
    output rd, rd_n, wr, wr_n, host_data_out, host_data_oe,
    input  host_data_bus, selected_indicator, transceiver_disable, irq_out, irq_out_oe
  );
endinterface : host_port_if
`default_nettype wire

// ### design/host_port_pkg.sv
// Purpose: Shared constants and types for the host bus port, both ends
// Assumes: One 250 MHz clock; all pins sampled on it
// Notes:   Register index codes and index-to-target decode below
package host_port_pkg;
  localparam int          DATA_W        = 8;
  localparam int          INDEX_W       = 3;
  localparam int          IRQ_SRC_W     = 4;
  localparam logic [2:0]  IDX_BUFFER    = 3'h0;
  localparam logic [2:0]  IDX_IRQ_EN    = 3'h1;
  localparam logic [2:0]  IDX_IRQ_ID    = 3'h2;
  localparam logic [2:0]  IDX_LINE_CTL  = 3'h3;
  localparam logic [2:0]  IDX_MODEM_CTL = 3'h4;
  localparam logic [2:0]  IDX_LINE_STAT = 3'h5;
  localparam logic [2:0]  IDX_MODEM_ST  = 3'h6;
  localparam logic [2:0]  IDX_SCRATCH   = 3'h7;
  localparam logic [7:0]  DATA_RESET    = 8'h00;
  localparam int          STROBE_CYCLES = 4;
  localparam int          ADDR_CYCLES   = 2;

  typedef enum logic [3:0] {
    reg_buffer, reg_irq_enable, reg_irq_ident, reg_line_control, reg_modem_control,
    reg_line_status, reg_modem_status, reg_scratch, reg_div_low, reg_div_high
  } reg_target_t;

  function automatic reg_target_t decode_target(input logic [2:0] idx, input logic divisor_access_bit);
    reg_target_t t;
    t = reg_scratch;
    if (idx == IDX_BUFFER) begin
      t = divisor_access_bit ? reg_div_low : reg_buffer;
    end else if (idx == IDX_IRQ_EN) begin
      t = divisor_access_bit ? reg_div_high : reg_irq_enable;
    end else if (idx == IDX_IRQ_ID) begin
      t = reg_irq_ident;
    end else if (idx == IDX_LINE_CTL) begin
      t = reg_line_control;
    end else if (idx == IDX_MODEM_CTL) begin
      t = reg_modem_control;
    end else if (idx == IDX_LINE_STAT) begin
      t = reg_line_status;
    end else if (idx == IDX_MODEM_ST) begin
      t = reg_modem_status;
    end
    return t;
  endfunction : decode_target
endpackage : host_port_pkg

// ### design/uart_host_bus_interface.sv
// Purpose: Device end of the host bus port of a byte-wide serial controller
// Assumes: Pins synchronous to clk; resetn is the master clear
// Notes:   Register contents live in the core behind the user-side ports
`timescale 1ns/100ps
`default_nettype none
module uart_host_bus_interface #(
  parameter bit REDUCED_PIN = 1'b0
) (
  // Clock and master clear
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Host pins
  host_port_if.device                   pins,
  // Core register side
  input  wire logic                     divisor_access_bit,
  input  wire logic [7:0]               read_data,
  output logic                          read_pulse,
  output logic                          write_pulse,
  output logic [7:0]                    write_data,
  output host_port_pkg::reg_target_t    reg_target,
  // Interrupt side
  input  wire logic [3:0]               irq_source,
  input  wire logic [3:0]               irq_enable_reg,
  input  wire logic                     user_output_two
);
  logic [2:0]                  index_latch;
  logic                        select_latch;
  logic                        selected;
  logic                        reading;
  logic                        writing;
  logic [7:0]                  data_out;
  logic                        data_oe;
  logic                        disable_q;
  logic                        irq_q;
  logic                        irq_oe_q;
  logic                        read_q;
  logic                        write_q;
  logic [7:0]                  wdata_q;
  host_port_pkg::reg_target_t  target_q;
  logic                        rd_pulse_q;
  logic                        wr_pulse_q;

  logic [2:0]                  next_index_latch;
  logic                        next_select_latch;
  logic                        next_selected;
  logic [7:0]                  next_data_out;
  logic                        next_data_oe;
  logic                        next_disable_q;
  logic                        next_irq_q;
  logic                        next_irq_oe_q;
  logic [7:0]                  next_wdata_q;
  host_port_pkg::reg_target_t  next_target_q;
  logic                        next_rd_pulse_q;
  logic                        next_wr_pulse_q;
  logic                        decoded_select;
  logic                        next_read_q;
  logic                        next_write_q;

  // Either strobe polarity starts a transfer; the host ties the other one inactive
  function automatic logic strobe_on(input logic active_high, input logic active_low_n);
    return active_high | ~active_low_n;
  endfunction : strobe_on

  // Address latch: follows the pins while the strobe is low, holds from its rising edge
  always_comb begin
    decoded_select    = pins.select_high_a & pins.select_high_b & ~pins.select_low_n;
    next_index_latch  = index_latch;
    next_select_latch = select_latch;
    if (!pins.address_latch_strobe_n) begin
      next_index_latch  = pins.register_index;
      next_select_latch = decoded_select;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      index_latch  <= host_port_pkg::IDX_BUFFER;
      select_latch <= 1'b0;
    end else begin
      index_latch  <= next_index_latch;
      select_latch <= next_select_latch;
    end
  end

  // Indicator lags the latch a cycle, so a host that waits on it never strobes early
  always_comb begin
    next_selected = select_latch;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      selected <= 1'b0;
    end else begin
      selected <= next_selected;
    end
  end

  // Data bus drive: strobes count only once the indicator already reads one
  always_comb begin
    reading        = selected & strobe_on(pins.rd, pins.rd_n);
    next_data_oe   = reading;
    next_data_out  = reading ? read_data : host_port_pkg::DATA_RESET;
    // Registered together, so transceiver and bus drive turn around in step
    next_disable_q = ~reading;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_out  <= host_port_pkg::DATA_RESET;
      data_oe   <= 1'b0;
      disable_q <= 1'b1;
    end else begin
      data_out  <= next_data_out;
      data_oe   <= next_data_oe;
      disable_q <= next_disable_q;
    end
  end

  // Core read side: decode of the latched index and a strobe-start pulse
  always_comb begin
    next_target_q   = host_port_pkg::decode_target(index_latch, divisor_access_bit);
    next_read_q     = reading;
    // Pulse at strobe start lets the core clear read-serviced sources
    next_rd_pulse_q = reading & ~read_q;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      target_q   <= host_port_pkg::reg_buffer;
      read_q     <= 1'b0;
      rd_pulse_q <= 1'b0;
    end else begin
      target_q   <= next_target_q;
      read_q     <= next_read_q;
      rd_pulse_q <= next_rd_pulse_q;
    end
  end

  // Core write side: bus sampled every strobe cycle, the last sample is kept
  always_comb begin
    writing         = selected & strobe_on(pins.wr, pins.wr_n);
    next_write_q    = writing;
    next_wdata_q    = writing ? pins.host_data_bus : wdata_q;
    // Pulse at strobe end, when host data has had time to settle
    next_wr_pulse_q = write_q & ~writing;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      write_q    <= 1'b0;
      wdata_q    <= host_port_pkg::DATA_RESET;
      wr_pulse_q <= 1'b0;
    end else begin
      write_q    <= next_write_q;
      wdata_q    <= next_wdata_q;
      wr_pulse_q <= next_wr_pulse_q;
    end
  end

  // Interrupt request: a level from the core sources, no flag held here
  always_comb begin
    next_irq_q    = |(irq_source & irq_enable_reg);
    // Full-pin parts drive the request pin whenever out of reset; reduced-pin parts gate it
    next_irq_oe_q = REDUCED_PIN ? user_output_two : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      irq_q    <= 1'b0;
      irq_oe_q <= 1'b0;
    end else begin
      irq_q    <= next_irq_q;
      irq_oe_q <= next_irq_oe_q;
    end
  end

  assign pins.dev_data_out        = data_out;
  assign pins.dev_data_oe         = data_oe;
  assign pins.selected_indicator  = selected;
  assign pins.transceiver_disable = disable_q;
  assign pins.irq_out             = irq_q;
  assign pins.irq_out_oe          = irq_oe_q;
  assign read_pulse               = rd_pulse_q;
  assign write_pulse              = wr_pulse_q;
  assign write_data               = wdata_q;
  assign reg_target               = target_q;
endmodule : uart_host_bus_interface
`default_nettype wire

// ### design/uart_host_bus_master.sv
// Purpose: Host end that runs register reads and writes over the pins
// Assumes: Same clk as the device end; active-low strobes used
// Notes:   Unused active-high strobes held at their inactive level
`timescale 1ns/100ps
`default_nettype none
module uart_host_bus_master #(
  parameter int STROBE_CYCLES = host_port_pkg::STROBE_CYCLES,
  parameter int ADDR_CYCLES   = host_port_pkg::ADDR_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Command side
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [2:0]  cmd_index,
  input  wire logic [7:0]  cmd_wdata,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [7:0]       rsp_rdata,
  output logic             irq_seen,
  // Device pins
  host_port_if.host        pins
);
  typedef enum {st_idle, st_addr, st_wait, st_strobe, st_release} state_t;

  state_t      state;
  logic [7:0]  count;
  logic        is_write;
  logic [2:0]  index_q;
  logic [7:0]  wdata_q;
  logic        strobe_n;
  logic        ads_n;
  logic        select_on;
  logic        ready_q;
  logic        rsp_q;
  logic [7:0]  rdata_q;
  logic        irq_q;

  state_t      next_state;
  logic [7:0]  next_count;
  logic        next_is_write;
  logic [2:0]  next_index_q;
  logic [7:0]  next_wdata_q;
  logic        next_strobe_n;
  logic        next_ads_n;
  logic        next_select_on;
  logic        next_ready_q;
  logic        next_rsp_q;
  logic [7:0]  next_rdata_q;

  always_comb begin
    next_state     = state;
    next_count     = count;
    next_is_write  = is_write;
    next_index_q   = index_q;
    next_wdata_q   = wdata_q;
    next_strobe_n  = 1'b1;
    next_ads_n     = ads_n;
    next_select_on = select_on;
    next_ready_q   = 1'b0;
    next_rsp_q     = 1'b0;
    next_rdata_q   = rdata_q;
    case (state)
      st_idle: begin
        if (cmd_valid && ready_q) begin
          next_is_write  = cmd_write;
          next_index_q   = cmd_index;
          next_wdata_q   = cmd_wdata;
          next_select_on = 1'b1;
          next_ads_n     = 1'b0;
          next_count     = 8'h00;
          next_state     = st_addr;
        end else begin
          next_ready_q = 1'b1;
        end
      end
      st_addr: begin
        next_count = count + 8'h01;
        if (count == 8'(ADDR_CYCLES - 1)) begin
          next_ads_n = 1'b1;
          next_state = st_wait;
        end
      end
      st_wait: begin
        if (pins.selected_indicator) begin
          next_strobe_n = 1'b0;
          next_count    = 8'h00;
          next_state    = st_strobe;
        end
      end
      st_strobe: begin
        next_count    = count + 8'h01;
        next_strobe_n = 1'b0;
        if (count == 8'(STROBE_CYCLES - 1)) begin
          next_strobe_n  = 1'b1;
          next_rdata_q   = pins.host_data_bus;
          next_rsp_q     = 1'b1;
          next_select_on = 1'b0;
          next_ads_n     = 1'b0;
          next_state     = st_release;
        end
      end
      st_release: begin
        // Strobe low once more so the device latches its deselection
        if (!pins.selected_indicator) begin
          next_ready_q = 1'b1;
          next_state   = st_idle;
        end
      end
      default: next_state = st_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state     <= st_idle;
      count     <= 8'h00;
      is_write  <= 1'b0;
      index_q   <= 3'h0;
      wdata_q   <= host_port_pkg::DATA_RESET;
      strobe_n  <= 1'b1;
      ads_n     <= 1'b0;
      select_on <= 1'b0;
      ready_q   <= 1'b0;
      rsp_q     <= 1'b0;
      rdata_q   <= host_port_pkg::DATA_RESET;
      irq_q     <= 1'b0;
    end else begin
      state     <= next_state;
      count     <= next_count;
      is_write  <= next_is_write;
      index_q   <= next_index_q;
      wdata_q   <= next_wdata_q;
      strobe_n  <= next_strobe_n;
      ads_n     <= next_ads_n;
      select_on <= next_select_on;
      ready_q   <= next_ready_q;
      rsp_q     <= next_rsp_q;
      rdata_q   <= next_rdata_q;
      irq_q     <= pins.irq_out & pins.irq_out_oe;
    end
  end

  assign pins.address_latch_strobe_n = ads_n;
  assign pins.select_high_a  = select_on;
  assign pins.select_high_b  = select_on;
  assign pins.select_low_n   = ~select_on;
  assign pins.register_index = index_q;
  assign pins.rd             = 1'b0;
  assign pins.rd_n           = strobe_n | is_write;
  assign pins.wr             = 1'b0;
  assign pins.wr_n           = strobe_n | ~is_write;
  assign pins.host_data_out  = wdata_q;
  assign pins.host_data_oe   = is_write & (state == st_strobe);
  assign cmd_ready           = ready_q;
  assign rsp_valid           = rsp_q;
  assign rsp_rdata           = rdata_q;
  assign irq_seen            = irq_q;
endmodule : uart_host_bus_master
`default_nettype wire

// ### tb/host_port_chk.sv
// Purpose: Pin-level checks on the host bus port joining the two ends
// Assumes: One clock; resetn synchronous, active low
// Notes:   Watches interface signals only; no bind
`timescale 1ns/100ps
`default_nettype none
module host_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Host pins
  input wire logic address_latch_strobe_n,
  input wire logic select_high_a,
  input wire logic select_high_b,
  input wire logic select_low_n,
  input wire logic rd,
  input wire logic rd_n,
  input wire logic wr,
  input wire logic wr_n,
  // Device pins
  input wire logic dev_data_oe,
  input wire logic selected_indicator,
  input wire logic transceiver_disable
);
  logic sel;
  logic rd_act;
  assign sel    = select_high_a & select_high_b & ~select_low_n;
  assign rd_act = selected_indicator & (rd | ~rd_n);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_sel_on;
    !address_latch_strobe_n && sel |-> ##2 selected_indicator;
  endproperty
  a_sel_on: assert property (p_sel_on) else $error("select not shown");
  property p_sel_off;
    !address_latch_strobe_n && !sel |-> ##2 !selected_indicator;
  endproperty
  a_sel_off: assert property (p_sel_off) else $error("deselect not shown");
  property p_hold;
    address_latch_strobe_n [*2] |=> $stable(selected_indicator);
  endproperty
  a_hold: assert property (p_hold) else $error("select changed while latched");
  property p_read;
    rd_act |=> dev_data_oe && !transceiver_disable;
  endproperty
  a_read: assert property (p_read) else $error("read not answered");
  property p_oe_cause;
    dev_data_oe |-> $past(rd_act);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  property p_refuse;
    !selected_indicator |=> !dev_data_oe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("strobe taken while unselected");
  property p_transceiver_disable;
    dev_data_oe != transceiver_disable;
  endproperty
  a_transceiver_disable: assert property (p_transceiver_disable) else $error("transceiver disable wrong");
  property p_host_strobe;
    !rd_n || !wr_n |-> selected_indicator && !rd && !wr && (rd_n || wr_n);
  endproperty
  a_host_strobe: assert property (p_host_strobe) else $error("host strobe misuse");
endmodule : host_port_chk
`default_nettype wire

// ### tb/testbench.sv
// Purpose: Self-checking bench for host and device ends of the bus port
// Assumes: 250 MHz clk; core side modelled by the bench
// Notes:   Second device end hand-driven for active-high strobes, refusals
`timescale 1ns/100ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic       rd;
    logic [7:0] val;
  } note_t;
  logic                       clk, resetn, cmd_valid, cmd_write, cmd_ready, rsp_valid, irq_seen;
  logic                       divisor_access_bit, user_output_two, read_pulse, write_pulse;
  logic                       read_pulse2, write_pulse2;
  logic [2:0]                 cmd_index;
  logic [3:0]                 irq_source, irq_enable_reg;
  logic [7:0]                 cmd_wdata, rsp_rdata, read_data, read_data2, write_data, write_data2, wd;
  host_port_pkg::reg_target_t reg_target, reg_target2;
  note_t                      rq[$];
  logic [11:0]                wq[$];
  int                         n_fail, checks_done, n_rd, n_rd2, n_wr2;
  host_port_if pins ();
  host_port_if pins2 ();
  // Core read value tagged by target so a wrong decode shows in the data
  assign read_data  = {4'h5, reg_target};
  assign read_data2 = {4'ha, reg_target2};
  uart_host_bus_master uart_host_bus_master_inst (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_index(cmd_index), .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_seen(irq_seen), .pins(pins));
  uart_host_bus_interface uart_host_bus_interface_inst (.clk(clk), .resetn(resetn), .pins(pins),
    .divisor_access_bit(divisor_access_bit), .read_data(read_data), .read_pulse(read_pulse),
    .write_pulse(write_pulse), .write_data(write_data), .reg_target(reg_target), .irq_source(irq_source),
    .irq_enable_reg(irq_enable_reg), .user_output_two(user_output_two));
  uart_host_bus_interface #(.REDUCED_PIN(1'b1)) uart_host_bus_interface_inst_b (.clk(clk), .resetn(resetn),
    .pins(pins2),
    .divisor_access_bit(divisor_access_bit), .read_data(read_data2), .read_pulse(read_pulse2),
    .write_pulse(write_pulse2), .write_data(write_data2), .reg_target(reg_target2),
    .irq_source(irq_source), .irq_enable_reg(irq_enable_reg), .user_output_two(user_output_two));
  host_port_chk host_port_chk_inst (.clk(clk), .resetn(resetn),
    .address_latch_strobe_n(pins.address_latch_strobe_n), .select_high_a(pins.select_high_a),
    .select_high_b(pins.select_high_b), .select_low_n(pins.select_low_n), .rd(pins.rd), .rd_n(pins.rd_n),
    .wr(pins.wr), .wr_n(pins.wr_n), .dev_data_oe(pins.dev_data_oe),
    .selected_indicator(pins.selected_indicator), .transceiver_disable(pins.transceiver_disable));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : summarize
  function automatic logic [3:0] exp_tgt(input logic [2:0] idx, input logic dab);
    if (dab && idx[2:1] == 2'h0) return {3'h4, idx[0]};
    return {1'b0, idx};
  endfunction : exp_tgt
  // Bounded wait for ready, optionally also for all answers
  task automatic wait_free(input bit drain);
    int i;
    for (i = 0; i < 300 && (cmd_ready !== 1'b1 || (drain && rq.size() != 0)); i++) tick(1);
    if (i == 300) begin
      n_fail++;
      summarize();
    end
  endtask : wait_free
  task automatic run_cmd(input logic w, input logic [2:0] idx, input logic [7:0] d);
    logic [3:0] t;
    t = exp_tgt(idx, divisor_access_bit);
    wait_free(1'b0);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_index = idx;
    cmd_wdata = d;
    if (w) wq.push_back({t, d});
    rq.push_back(w ? note_t'{1'b0, 8'h00} : note_t'{1'b1, {4'h5, t}});
    tick(1);
    cmd_valid = 1'b0;
  endtask : run_cmd
  // Active-high strobes on the second end; active-low ones stay tied off
  task automatic drive2(input logic [3:0] s, input logic r, input logic w, input logic [7:0] d);
    pins2.address_latch_strobe_n = s[3];
    pins2.select_low_n           = s[2];
    pins2.select_high_b          = s[1];
    pins2.select_high_a          = s[0];
    pins2.rd                     = r;
    pins2.wr                     = w;
    pins2.host_data_oe           = w;
    pins2.host_data_out          = d;
  endtask : drive2
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    note_t nt;
    if (read_pulse === 1'b1) n_rd++;
    if (read_pulse2 === 1'b1) n_rd2++;
    if (write_pulse2 === 1'b1) n_wr2++;
    if (write_pulse === 1'b1) begin
      if (wq.size() == 0) check(12'h000, 12'h001);
      else check({reg_target, write_data}, wq.pop_front());
    end
    if (rsp_valid === 1'b1) begin
      if (rq.size() == 0) check(12'h000, 12'h001);
      else begin
        nt = rq.pop_front();
        if (nt.rd) check({4'h0, rsp_rdata}, {4'h0, nt.val});
      end
    end
  end
  initial begin
    n_fail = 0;
    checks_done = 0;
    n_rd = 0;
    n_rd2 = 0;
    n_wr2 = 0;
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_index = 3'h0;
    cmd_wdata = 8'h00;
    divisor_access_bit = 1'b0;
    user_output_two = 1'b0;
    irq_source = 4'h0;
    irq_enable_reg = 4'h0;
    pins2.rd_n = 1'b1;
    pins2.wr_n = 1'b1;
    pins2.register_index = 3'h0;
    drive2(4'h8, 1'b0, 1'b0, 8'h00);
    void'($urandom(16));
    tick(8);
    resetn = 1'b1;
    for (int d = 0; d < 2; d++) begin
      divisor_access_bit = d[0];
      for (int i = 0; i < 8; i++) begin
        wd = 8'($urandom());
        run_cmd(1'b1, 3'(i), wd);
        run_cmd(1'b0, 3'(i), 8'h00);
      end
      wait_free(1'b1);
      tick(4);
    end
    check({4'h0, n_rd[7:0]}, 12'h010);
    for (int k = 0; k < 8; k++) begin
      irq_source = 4'($urandom());
      irq_enable_reg = 4'($urandom());
      user_output_two = 1'($urandom());
      tick(3);
      check({11'h0, irq_seen}, {11'h0, |(irq_source & irq_enable_reg)});
      check({11'h0, pins2.irq_out_oe}, {11'h0, user_output_two});
      irq_source = 4'h0;
      tick(3);
      check({11'h0, irq_seen}, 12'h000);
    end
    irq_source = 4'hf;
    irq_enable_reg = 4'hf;
    tick(3);
    resetn = 1'b0;
    tick(2);
    check({11'h0, pins.irq_out}, 12'h000);
    resetn = 1'b1;
    irq_source = 4'h0;
    tick(2);
    pins2.register_index = 3'($urandom());
    for (int s = 0; s < 8; s++) begin
      drive2({1'b0, 3'(s)}, 1'b0, 1'b0, 8'h00);
      tick(3);
      check({11'h0, pins2.selected_indicator}, {11'h0, s == 3});
    end
    // Selects active but never captured: strobe must be ignored
    drive2(4'hb, 1'b1, 1'b0, 8'h00);
    tick(4);
    check({n_rd2[3:0], 7'h0, pins2.dev_data_oe}, 12'h000);
    drive2(4'h3, 1'b0, 1'b0, 8'h00);
    tick(3);
    drive2(4'h8, 1'b0, 1'b0, 8'h00);
    tick(3);
    check({11'h0, pins2.selected_indicator}, 12'h001);
    drive2(4'h8, 1'b1, 1'b0, 8'h00);
    tick(2);
    check({3'h0, pins2.transceiver_disable, pins2.host_data_bus},
          {4'h0, 4'ha, exp_tgt(pins2.register_index, divisor_access_bit)});
    drive2(4'h8, 1'b0, 1'b0, 8'h00);
    tick(2);
    wd = 8'($urandom());
    drive2(4'h8, 1'b0, 1'b1, wd);
    tick(3);
    drive2(4'h8, 1'b0, 1'b0, wd);
    tick(3);
    check({n_wr2[1:0], n_rd2[1:0], write_data2}, {2'h1, 2'h1, wd});
    summarize();
  end
endmodule : testbench
`default_nettype wire
